/* File: core_model.sv */
// core partner: issues wait instructions and wake-up events
`default_nettype none
module core_model (
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire logic [2:0] mode_i,
	input  wire logic [3:0] dly_i,
	output logic            wfi_o,
	output logic            irq_o,
	output logic            wake_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int n = 0;
	// wait pulse on request; wake after a delay once asleep; drop once running
	always @(negedge clk_i) begin
		wfi_o <= go_i;
		n <= (mode_i < 3'h3) ? 0 : n + 1;
		irq_o <= (mode_i inside {3'h3, 3'h4}) && n >= dly_i;
		if (mode_i < 3'h3) wake_o <= 1'b0;
		else if (mode_i inside {3'h5, 3'h6} && n >= dly_i) wake_o <= #7 1'b1;
	end
endmodule
`default_nettype wire

/* File: pmwc_checker.sv */
// concurrent checks on the power mode controller ports
`default_nettype none
module pmwc_checker (
	input wire logic       sys_clk_i,
	input wire logic       reset_i,
	input wire logic       deep_sleep_sel_i,
	input wire logic       wait_instr_i,
	input wire logic       irq_pending_i,
	input wire logic [2:0] mode_o,
	input wire logic       core_active_o,
	input wire logic       voltage_monitor_en_o,
	input wire logic       irq_ctrl_en_o,
	input wire logic       async_wake_en_o,
	input wire logic       high_freq_allow_o,
	input wire logic       clk_restart_req_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	wire logic run = mode_o < 3'h3;
	// leaving deep sleep passes through clock restart, then back to run
	sequence s_restart;
		clk_restart_req_o ##[1:40] run;
	endsequence
	a_wait_enter: assert property (run && wait_instr_i && !deep_sleep_sel_i
		|=> mode_o inside {3'h3, 3'h4}) else $error("wait entry wrong");
	a_stop_enter: assert property (run && wait_instr_i && deep_sleep_sel_i
		|=> mode_o inside {3'h5, 3'h6}) else $error("stop entry wrong");
	a_irq_wake: assert property (mode_o inside {3'h3, 3'h4} && irq_pending_i |=> run)
		else $error("irq did not wake");
	a_stop_holds: assert property (mode_o inside {3'h5, 3'h6}
		|=> mode_o inside {3'h5, 3'h6, 3'h7}) else $error("stop left early");
	a_wake_restart: assert property ($fell(async_wake_en_o) |-> s_restart)
		else $error("no clock restart on wake");
	a_core_run: assert property (core_active_o == run)
		else $error("core state wrong");
	a_high_speed_run_mode_freq: assert property (high_freq_allow_o == (mode_o == 3'h0))
		else $error("high frequency flag wrong");
	a_monitor_off: assert property (voltage_monitor_en_o !=
		(mode_o inside {3'h2, 3'h4, 3'h6})) else $error("voltage monitor wrong");
	a_wake_ctrl: assert property (async_wake_en_o == (mode_o inside {3'h5, 3'h6})
		&& irq_ctrl_en_o == (mode_o < 3'h5)) else $error("wake control wrong");
endmodule
`default_nettype wire

/* File: power_mode_wake_controller.sv */
// power mode controller: run, wait and stop configurations with wake-up
// What this block does
// [R1] wait instruction enters sleep or deep-sleep class mode by current selection
// [R2] all run configurations keep core active with every peripheral enabled
// [R3] high speed run permits clocking above the normal run limit
// [R4] wait configurations halt core while all peripherals keep running
// [R5] stop configurations disable core and most peripherals; retention depends on mode
// [R6] very low power run turns off the low-voltage monitor, reduced clock
// [R7] very low power wait turns off the low-voltage monitor, core sleeps
// [R8] stop: clocks gated, registers and SRAM kept, monitor on, irq ctrl off
// [R9] very low power stop: SRAM kept, low-power peripherals and DMA on, monitor off
// [R10] an interrupt at the irq controller wakes the core from wait configurations
// [R11] the async wake-up controller detects clockless wakes and leaves stop modes
// [R12] async wake requests clock restart, then irq controller takes the interrupt
// [R13] wake-up returns to the run configuration active before the wait instruction
`include "pwr_mode_defines.svh"
`default_nettype none
module power_mode_wake_controller #(
	parameter int RESTART_CYCLES = `CLK_RESTART_CYC
) (
	input  wire logic       sys_clk_i,
	input  wire logic       reset_i,
	input  wire logic [1:0] run_sel_i,
	input  wire logic       deep_sleep_sel_i,
	input  wire logic       wait_instr_i,
	input  wire logic       irq_pending_i,
	input  wire logic       async_wake_i,
	output logic [2:0]      mode_o,
	output logic            core_active_o,
	output logic            periph_clk_en_o,
	output logic            low_power_periph_en_o,
	output logic            dma_en_o,
	output logic            sram_retain_o,
	output logic            reg_retain_o,
	output logic            voltage_monitor_en_o,
	output logic            irq_ctrl_en_o,
	output logic            async_wake_en_o,
	output logic            high_freq_allow_o,
	output logic            reduced_freq_o,
	output logic            clk_restart_req_o
);
	pwr_mode_pkg::pwr_mode_e mode_r;
	pwr_mode_pkg::pwr_mode_e mode_nxt;
	logic [1:0]              saved_run_r;
	logic [7:0]              restart_cnt_r;
	logic                    wake_lvl;
	logic                    wake_lvl_d_r;

	wake_sync u_wake_sync (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.async_i   (async_wake_i),
		.level_o   (wake_lvl)
	);

	// maps a run selection to its run mode
	function automatic pwr_mode_pkg::pwr_mode_e run_mode(input logic [1:0] sel);
		case (sel)
			`RUN_SEL_FAST: run_mode = pwr_mode_pkg::high_speed_run_mode;
			`RUN_SEL_SLOW: run_mode = pwr_mode_pkg::very_low_power_run_mode;
			default:       run_mode = pwr_mode_pkg::normal_run_mode;
		endcase
	endfunction

	// true for the three run configurations
	function automatic logic is_run(input pwr_mode_pkg::pwr_mode_e m);
		is_run = (m == pwr_mode_pkg::high_speed_run_mode) ||
		         (m == pwr_mode_pkg::normal_run_mode) ||
		         (m == pwr_mode_pkg::very_low_power_run_mode);
	endfunction

	// true for the two sleep-class configurations
	function automatic logic is_wait(input pwr_mode_pkg::pwr_mode_e m);
		is_wait = (m == pwr_mode_pkg::wait_mode) ||
		          (m == pwr_mode_pkg::very_low_power_wait_mode);
	endfunction

	// run selection code that brings a given run mode back on wake-up
	function automatic logic [1:0] run_code(input pwr_mode_pkg::pwr_mode_e m);
		case (m)
			pwr_mode_pkg::high_speed_run_mode:     run_code = `RUN_SEL_FAST;
			pwr_mode_pkg::very_low_power_run_mode: run_code = `RUN_SEL_SLOW;
			default:                               run_code = `RUN_SEL_RUN;
		endcase
	endfunction

	// classification of the current and next mode
	wire       in_run          = is_run(mode_r);
	wire       from_slow       = (mode_r == pwr_mode_pkg::very_low_power_run_mode);
	wire       sleep_entry     = in_run & wait_instr_i; // [R1]
	wire       wake_edge       = wake_lvl & ~wake_lvl_d_r;
	wire       restart_end     = (restart_cnt_r >= 8'(RESTART_CYCLES - 1));
	wire       n_run           = is_run(mode_nxt);
	wire       n_wait          = is_wait(mode_nxt);
	wire       n_stop          = (mode_nxt == pwr_mode_pkg::stop_mode);
	wire       n_deep_slow     = (mode_nxt == pwr_mode_pkg::very_low_power_stop_mode);
	wire       n_restart       = (mode_nxt == pwr_mode_pkg::clock_restart_mode);
	wire       n_vlp           = (mode_nxt == pwr_mode_pkg::very_low_power_run_mode) ||
	                             (mode_nxt == pwr_mode_pkg::very_low_power_wait_mode);
	// the run mode is captured at the wait instruction, so a later selection cannot leak in
	wire [1:0] saved_run_nxt   = sleep_entry ? run_code(mode_r) : saved_run_r; // [R13]
	wire [7:0] restart_cnt_nxt = (mode_r == pwr_mode_pkg::clock_restart_mode) ?
	                             (restart_cnt_r + 8'h01) : 8'h00;

	// next levels of the mode-dependent controls, registered below
	wire       core_active_nxt   = n_run; // [R2] [R4] [R5]
	wire       periph_clk_en_nxt = n_run | n_wait; // [R4] [R5] [R8]
	wire       low_power_en_nxt  = ~n_restart; // [R8] [R9]
	wire       dma_en_nxt        = ~n_stop & ~n_restart; // [R9]
	wire       reg_retain_nxt    = ~n_deep_slow; // [R5] [R8]
	wire       monitor_en_nxt    = ~n_vlp & ~n_deep_slow; // [R6] [R7] [R8] [R9]
	wire       irq_ctrl_en_nxt   = n_run | n_wait; // [R8] [R9] [R10]
	wire       async_wake_en_nxt = n_stop | n_deep_slow; // [R11]
	wire       high_freq_nxt     = (mode_nxt == pwr_mode_pkg::high_speed_run_mode); // [R3]
	wire       reduced_freq_nxt  = n_vlp; // [R6] [R7]

	// next-state logic
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			pwr_mode_pkg::high_speed_run_mode,
			pwr_mode_pkg::normal_run_mode,
			pwr_mode_pkg::very_low_power_run_mode: begin
				if (wait_instr_i) begin // [R1]
					if (deep_sleep_sel_i) begin
						mode_nxt = from_slow ? pwr_mode_pkg::very_low_power_stop_mode
						                     : pwr_mode_pkg::stop_mode;
					end else begin
						mode_nxt = from_slow ? pwr_mode_pkg::very_low_power_wait_mode
						                     : pwr_mode_pkg::wait_mode;
					end
				end else begin
					mode_nxt = run_mode(run_sel_i);
				end
			end
			pwr_mode_pkg::wait_mode,
			pwr_mode_pkg::very_low_power_wait_mode: begin
				if (irq_pending_i) begin // [R10]
					mode_nxt = run_mode(saved_run_r); // [R13]
				end
			end
			pwr_mode_pkg::stop_mode,
			pwr_mode_pkg::very_low_power_stop_mode: begin
				if (wake_edge) begin // [R11]
					mode_nxt = pwr_mode_pkg::clock_restart_mode;
				end
			end
			pwr_mode_pkg::clock_restart_mode: begin
				if (restart_end) begin // [R12]
					mode_nxt = run_mode(saved_run_r); // [R13]
				end
			end
			default: mode_nxt = pwr_mode_pkg::normal_run_mode;
		endcase
	end

	// mode register and wake level history for the edge detector
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			mode_r       <= pwr_mode_pkg::normal_run_mode;
			wake_lvl_d_r <= 1'b0;
		end else begin
			mode_r       <= mode_nxt;
			wake_lvl_d_r <= wake_lvl;
		end
	end

	// run configuration to come back to after a wake-up
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			saved_run_r <= `RESET_RUN_SEL;
		end else begin
			saved_run_r <= saved_run_nxt; // [R13]
		end
	end

	// clock restart interval counter, cleared outside the restart state
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			restart_cnt_r <= 8'h00;
		end else begin
			restart_cnt_r <= restart_cnt_nxt; // [R12]
		end
	end

	// mode code seen by the rest of the chip
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			mode_o <= `RESET_MODE_CODE;
		end else begin
			mode_o <= mode_nxt;
		end
	end

	// core, peripheral and retention controls
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			core_active_o         <= 1'b1;
			periph_clk_en_o       <= 1'b1;
			low_power_periph_en_o <= 1'b1;
			dma_en_o              <= 1'b1;
			sram_retain_o         <= 1'b1;
			reg_retain_o          <= 1'b1;
		end else begin
			core_active_o         <= core_active_nxt; // [R2] [R4] [R5]
			periph_clk_en_o       <= periph_clk_en_nxt; // [R4] [R5] [R8]
			low_power_periph_en_o <= low_power_en_nxt; // [R8] [R9]
			dma_en_o              <= dma_en_nxt; // [R9]
			sram_retain_o         <= 1'b1; // [R8] [R9]
			reg_retain_o          <= reg_retain_nxt; // [R5] [R8]
		end
	end

	// voltage monitor and wake-up source controls
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			voltage_monitor_en_o <= 1'b1;
			irq_ctrl_en_o        <= 1'b1;
			async_wake_en_o      <= 1'b0;
		end else begin
			voltage_monitor_en_o <= monitor_en_nxt; // [R6] [R7] [R8] [R9]
			irq_ctrl_en_o        <= irq_ctrl_en_nxt; // [R8] [R9] [R10]
			async_wake_en_o      <= async_wake_en_nxt; // [R11]
		end
	end

	// clock frequency limits and the clock restart request
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			high_freq_allow_o <= 1'b0;
			reduced_freq_o    <= 1'b0;
			clk_restart_req_o <= 1'b0;
		end else begin
			high_freq_allow_o <= high_freq_nxt; // [R3]
			reduced_freq_o    <= reduced_freq_nxt; // [R6] [R7]
			clk_restart_req_o <= n_restart; // [R12]
		end
	end
endmodule
`default_nettype wire

/* File: pwr_mode_defines.svh */
// power mode controller constants
`ifndef PWR_MODE_DEFINES_SVH
`define PWR_MODE_DEFINES_SVH
`define RUN_SEL_FAST       2'h0
`define RUN_SEL_RUN        2'h1
`define RUN_SEL_SLOW       2'h2
`define RESET_RUN_SEL      2'h1
`define RESET_MODE_CODE    3'h1
`define CLK_RESTART_NS     100
`define CLK_RESTART_CYC    ((`CLK_RESTART_NS + 19) / 20)
`define SYNC_STAGES        3
`endif

/* File: pwr_mode_pkg.sv */
// power mode controller types
`default_nettype none
package pwr_mode_pkg;
	typedef enum logic [2:0] {
		high_speed_run_mode      = 3'h0,
		normal_run_mode          = 3'h1,
		very_low_power_run_mode  = 3'h2,
		wait_mode                = 3'h3,
		very_low_power_wait_mode = 3'h4,
		stop_mode                = 3'h5,
		very_low_power_stop_mode = 3'h6,
		clock_restart_mode       = 3'h7
	} pwr_mode_e;
endpackage
`default_nettype wire

/* File: tb_power_mode_wake_controller.sv */
// self-checking bench for the power mode wake controller
`default_nettype none
module tb_power_mode_wake_controller;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [1:0] run_sel_i = 2'h1;
	logic deep_sleep_sel_i = 1'b0;
	logic go = 1'b0;
	logic [3:0] dly = 4'h0;
	logic [31:0] seed = 32'h85EE;
	logic [2:0] m, s, mode_o;
	logic wait_instr_i, irq_pending_i, async_wake_i, core_active_o, periph_clk_en_o;
	logic low_power_periph_en_o, dma_en_o, sram_retain_o, reg_retain_o, voltage_monitor_en_o;
	logic irq_ctrl_en_o, async_wake_en_o, high_freq_allow_o, reduced_freq_o, clk_restart_req_o;
	wire logic [11:0] ctl = {core_active_o, periph_clk_en_o, low_power_periph_en_o, dma_en_o,
		sram_retain_o, reg_retain_o, voltage_monitor_en_o, irq_ctrl_en_o, async_wake_en_o,
		high_freq_allow_o, reduced_freq_o, clk_restart_req_o};
	int failures = 0;
	int samples_checked = 0;
	int k;
	power_mode_wake_controller #(.RESTART_CYCLES(2)) uut (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i), .run_sel_i(run_sel_i),
		.deep_sleep_sel_i(deep_sleep_sel_i), .wait_instr_i(wait_instr_i),
		.irq_pending_i(irq_pending_i), .async_wake_i(async_wake_i), .mode_o(mode_o),
		.core_active_o(core_active_o), .periph_clk_en_o(periph_clk_en_o),
		.low_power_periph_en_o(low_power_periph_en_o), .dma_en_o(dma_en_o),
		.sram_retain_o(sram_retain_o), .reg_retain_o(reg_retain_o),
		.voltage_monitor_en_o(voltage_monitor_en_o), .irq_ctrl_en_o(irq_ctrl_en_o),
		.async_wake_en_o(async_wake_en_o), .high_freq_allow_o(high_freq_allow_o),
		.reduced_freq_o(reduced_freq_o), .clk_restart_req_o(clk_restart_req_o));
	core_model core (.clk_i(sys_clk_i), .go_i(go), .mode_i(mode_o), .dly_i(dly),
		.wfi_o(wait_instr_i), .irq_o(irq_pending_i), .wake_o(async_wake_i));
	always #10 sys_clk_i = ~sys_clk_i;
	// expected control levels for a mode
	function automatic logic [11:0] exp_ctl(input logic [2:0] e);
		return {e < 3'h3, e < 3'h5, e != 3'h7, !(e inside {3'h5, 3'h7}), 1'b1, e != 3'h6,
			!(e inside {3'h2, 3'h4, 3'h6}), e < 3'h5, e inside {3'h5, 3'h6}, e == 3'h0,
			e inside {3'h2, 3'h4}, e == 3'h7};
	endfunction
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task automatic chk(input logic [2:0] want);
		samples_checked++;
		if ({mode_o, ctl} !== {want, exp_ctl(want)}) begin
			failures++;
			$display("MISMATCH t=%0t got=%h want=%h", $time,
				{mode_o, ctl}, {want, exp_ctl(want)});
		end
	endtask
	task automatic end_of_test;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// every selection first, then random runs with a run selection change while asleep
	initial begin
		repeat (8) @(posedge sys_clk_i);
		@(negedge sys_clk_i) reset_i = 1'b0;
		for (int i = 0; i < 40; i++) begin
			// mid-run reset: controls must return to their normal run levels
			if (i == 20) begin
				reset_i = 1'b1;
				repeat (2) @(negedge sys_clk_i);
				chk(3'h1);
				reset_i = 1'b0;
			end
			seed = xs(seed);
			run_sel_i = (i < 8) ? i[1:0] : seed[1:0];
			deep_sleep_sel_i = (i < 8) ? i[2] : seed[2];
			dly = seed[6:3];
			repeat (2) @(negedge sys_clk_i);
			m = (run_sel_i == 2'h3) ? 3'h1 : {1'b0, run_sel_i};
			chk(m);
			go <= 1'b1;
			@(negedge sys_clk_i) go <= 1'b0;
			@(negedge sys_clk_i);
			s = deep_sleep_sel_i ? ((m == 3'h2) ? 3'h6 : 3'h5) : ((m == 3'h2) ? 3'h4 : 3'h3);
			chk(s);
			run_sel_i = ~run_sel_i;
			for (k = 0; k < 60 && mode_o > 3'h2; k++) begin
				if (mode_o == 3'h7) chk(3'h7);
				@(negedge sys_clk_i);
			end
			if (k == 60) begin
				failures++;
				end_of_test();
			end
			chk(m);
		end
		end_of_test();
	end
endmodule
bind power_mode_wake_controller pmwc_checker u_chk (
	.sys_clk_i(sys_clk_i), .reset_i(reset_i), .deep_sleep_sel_i(deep_sleep_sel_i),
	.wait_instr_i(wait_instr_i), .irq_pending_i(irq_pending_i), .mode_o(mode_o),
	.core_active_o(core_active_o), .voltage_monitor_en_o(voltage_monitor_en_o),
	.irq_ctrl_en_o(irq_ctrl_en_o), .async_wake_en_o(async_wake_en_o),
	.high_freq_allow_o(high_freq_allow_o), .clk_restart_req_o(clk_restart_req_o));
`default_nettype wire

/* File: wake_sync.sv */
// three-stage synchroniser for the asynchronous wake request
`include "pwr_mode_defines.svh"
`default_nettype none
module wake_sync (
	input  wire logic sys_clk_i,
	input  wire logic reset_i,
	input  wire logic async_i,
	output logic      level_o
);
	logic [`SYNC_STAGES-1:0] stage_r;

	// shift the pin through the chain; change counts once last two agree
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			stage_r <= 3'h0;
			level_o <= 1'b0;
		end else begin
			stage_r <= {stage_r[1:0], async_i};
			if (stage_r[2] == stage_r[1]) begin
				level_o <= stage_r[2];
			end
		end
	end
endmodule
`default_nettype wire
